// [bcd_counter.sv]
// Dual-clock BCD up/down counter with load, clear, carry and borrow
`timescale 1ns/1ps
`default_nettype none
// Contract
// - All four count bits update together on one shared clock edge.
// - Count advances on a rising edge of the up or down input.
// - Direction follows the input that rose while the other stays high.
// - Low load forces count to the data inputs, regardless of count inputs.
// - High clear forces count to zero regardless of count and load.
// - Clear wins over load, data and both count inputs.
// - Decimal counting: nine wraps up to zero, zero wraps down to nine.
// - Borrow low only while count is zero and down input was low at the previous mclk sample.
// - Carry low only while count is nine and up input was low at the previous mclk sample.
module bcd_counter
  import bcd_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Count inputs, sampled on mclk
  input  wire logic count_up,
  input  wire logic count_down,
  // Load and clear
  input  wire logic load_n,
  input  wire logic async_clear,
  // Parallel data, bit 0 least significant
  input  wire logic [3:0] load_data,
  // Count outputs
  output logic      count_bit0,
  output logic      count_bit1,
  output logic      count_bit2,
  output logic      count_bit3,
  // Cascade outputs, active low
  output logic      carry_out_n,
  output logic      borrow_out_n
);
  // Step link to the decade unit
  bcd_step_if sif ();

  // Edge history of both count inputs
  logic       up_d_r;
  logic       up_d_nxt;
  logic       dn_d_r;
  logic       dn_d_nxt;

  // Decoded count edges and the operation for this edge
  logic       up_rise;
  logic       dn_rise;
  logic       up_edge;
  logic       dn_edge;
  bcd_op_t    op;

  // Count register
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  // Terminal values of the next count
  logic       nxt_at_max;
  logic       nxt_at_zero;

  // Cascade flags, active low
  logic       carry_r;
  logic       carry_nxt;
  logic       borrow_r;
  logic       borrow_nxt;

  // Low-to-high step of one input between two samples
  function automatic logic rose(
    input logic now,
    input logic was
  );
    rose = now && !was;
  endfunction : rose

  // A rise counts only while the other input stood high on both samples
  function automatic logic counts(
    input logic rise,
    input logic other_now,
    input logic other_was
  );
    logic other_high;
    other_high = other_now && other_was;
    counts     = rise && other_high;
  endfunction : counts

  // Active-low cascade level: low at the terminal value while its input is low
  function automatic logic cascade_level(
    input logic at_end,
    input logic cnt_in
  );
    cascade_level = !(at_end && !cnt_in);
  endfunction : cascade_level

  // Decade step unit
  bcd_step u_step (
    .s (sif.step)
  );

  // Raw rises of each count input
  always_comb begin
    up_rise = rose(count_up, up_d_r);
    dn_rise = rose(count_down, dn_d_r);
  end

  // Qualified edges: the idle input must stand high around the rise
  always_comb begin
    up_edge = counts(up_rise, count_down, dn_d_r);
    dn_edge = counts(dn_rise, count_up, up_d_r);
  end

  // Pick operation: load beats counting, counting beats hold
  always_comb begin
    op = BCD_OP_HOLD;
    if (!load_n) begin
      op = BCD_OP_LOAD;
    end else if (up_edge) begin
      op = BCD_OP_UP;
    end else if (dn_edge) begin
      op = BCD_OP_DOWN;
    end
  end

  // Drive the step link
  assign sif.cur      = cnt_r;
  assign sif.op       = op;
  assign sif.load_val = load_data;

  // Up history next value: the level sampled at this edge
  always_comb begin
    up_d_nxt = count_up;
  end

  // Up history register; idle high so leaving reset makes no false edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      up_d_r <= CNT_IN_IDLE;
    end else begin
      up_d_r <= up_d_nxt;
    end
  end

  // Down history next value: the level sampled at this edge
  always_comb begin
    dn_d_nxt = count_down;
  end

  // Down history register, idle high as well
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dn_d_r <= CNT_IN_IDLE;
    end else begin
      dn_d_r <= dn_d_nxt;
    end
  end

  // Count next value: clear overrides load and both count inputs
  always_comb begin
    cnt_nxt = sif.nxt;
    if (async_clear) begin
      cnt_nxt = CNT_ZERO;
    end
  end

  // Count register: all four bits share one edge, so nothing ripples
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= CNT_ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Terminal detection on the value the count is about to take
  always_comb begin
    nxt_at_max  = (cnt_nxt == CNT_MAX);
    nxt_at_zero = (cnt_nxt == CNT_ZERO);
  end

  // Carry next value: the flag lags the up input by one sample
  always_comb begin
    carry_nxt = cascade_level(nxt_at_max, count_up);
  end

  // Carry register, idle high
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      carry_r <= FLAG_IDLE;
    end else begin
      carry_r <= carry_nxt;
    end
  end

  // Borrow next value: the flag lags the down input by one sample
  always_comb begin
    borrow_nxt = cascade_level(nxt_at_zero, count_down);
  end

  // Borrow register, idle high
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      borrow_r <= FLAG_IDLE;
    end else begin
      borrow_r <= borrow_nxt;
    end
  end

  // Count pins straight from the count register, bit 0 least significant
  always_comb begin
    count_bit0 = cnt_r[Q0_POS];
    count_bit1 = cnt_r[Q1_POS];
    count_bit2 = cnt_r[Q2_POS];
    count_bit3 = cnt_r[Q3_POS];
  end

  // Cascade pins straight from their flags
  always_comb begin
    carry_out_n  = carry_r;
    borrow_out_n = borrow_r;
  end
endmodule : bcd_counter
`default_nettype wire

// [bcd_pkg.sv]
// Package for the dual-clock BCD up/down counter
package bcd_pkg;
  localparam int         CNT_W    = 4;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_MAX  = 4'h9;
  localparam logic [3:0] CNT_ONE  = 4'h1;

  // Idle level of a count input and of a cascade flag
  localparam logic       CNT_IN_IDLE = 1'b1;
  localparam logic       FLAG_IDLE   = 1'b1;

  // Bit positions of the count outputs
  localparam int         Q0_POS   = 0;
  localparam int         Q1_POS   = 1;
  localparam int         Q2_POS   = 2;
  localparam int         Q3_POS   = 3;

  // Count operation chosen each cycle
  typedef enum logic [1:0] {
    BCD_OP_HOLD  = 2'b00,
    BCD_OP_UP    = 2'b01,
    BCD_OP_DOWN  = 2'b10,
    BCD_OP_LOAD  = 2'b11
  } bcd_op_t;
endpackage : bcd_pkg

// [bcd_step_if.sv]
// Interface between the counter top and its decade step unit
`timescale 1ns/1ps
`default_nettype none
interface bcd_step_if;
  import bcd_pkg::*;
  logic [3:0] cur;
  bcd_op_t    op;
  logic [3:0] load_val;
  logic [3:0] nxt;
  modport top  (output cur, output op, output load_val, input nxt);
  modport step (input cur, input op, input load_val, output nxt);
endinterface : bcd_step_if
`default_nettype wire

// [bcd_step.sv]
// Decade step unit: next count value from the current one
`timescale 1ns/1ps
`default_nettype none
module bcd_step
  import bcd_pkg::*;
(
  // Step link
  bcd_step_if.step s
);
  // Wrap up past nine to zero
  function automatic logic [3:0] bcd_inc(input logic [3:0] v);
    bcd_inc = (v >= CNT_MAX) ? CNT_ZERO : 4'(v + CNT_ONE);
  endfunction : bcd_inc

  // Wrap down past zero to nine
  function automatic logic [3:0] bcd_dec(input logic [3:0] v);
    bcd_dec = (v == CNT_ZERO) ? CNT_MAX : 4'(v - CNT_ONE);
  endfunction : bcd_dec

  // Select next value by operation
  always_comb begin
    case (s.op)
      BCD_OP_UP:   s.nxt = bcd_inc(s.cur);
      BCD_OP_DOWN: s.nxt = bcd_dec(s.cur);
      BCD_OP_LOAD: s.nxt = s.load_val;
      default:     s.nxt = s.cur;
    endcase
  end
endmodule : bcd_step
`default_nettype wire

// [bcd_counter_sva.sv]
// Assertion checker for the BCD counter
`timescale 1ns/1ps
`default_nettype none
module bcd_counter_sva (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // Count, load and clear inputs
  input wire logic       count_up,
  input wire logic       count_down,
  input wire logic       load_n,
  input wire logic       async_clear,
  input wire logic [3:0] load_data,
  // Count and cascade outputs
  input wire logic       count_bit0,
  input wire logic       count_bit1,
  input wire logic       count_bit2,
  input wire logic       count_bit3,
  input wire logic       carry_out_n,
  input wire logic       borrow_out_n
);
  wire logic [3:0] q = {count_bit3, count_bit2, count_bit1, count_bit0};
  wire logic run = load_n && !async_clear;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_clear_zero: assert property (async_clear |=> q == 4'h0) else $error("clear");
  a_clear_wins: assert property (async_clear && !load_n |=> q == 4'h0) else $error("clear order");
  a_load_data: assert property (!load_n && !async_clear |=> q == $past(load_data)) else $error("load");
  a_count_up: assert property (run && $rose(count_up) && count_down && $past(count_down)
    |=> q == ($past(q) >= 4'h9 ? 4'h0 : $past(q) + 4'h1)) else $error("up");
  a_count_down: assert property (run && $rose(count_down) && count_up && $past(count_up)
    |=> q == ($past(q) == 4'h0 ? 4'h9 : $past(q) - 4'h1)) else $error("down");
  a_count_hold: assert property (run && count_up && count_down && $past(count_up) && $past(count_down)
    |=> $stable(q)) else $error("hold");
  a_carry_low: assert property (1'b1 |=> carry_out_n == !(q == 4'h9 && !$past(count_up))) else $error("carry");
  a_borrow_low: assert property (1'b1 |=> borrow_out_n == !(q == 4'h0 && !$past(count_down))) else $error("borrow");
  c_up: cover property (run && $rose(count_up));
  c_down: cover property (run && $rose(count_down));
  c_carry: cover property (!carry_out_n);
  c_borrow: cover property (!borrow_out_n);
endmodule : bcd_counter_sva
bind bcd_counter bcd_counter_sva i_sva (
  .mclk         (mclk),
  .rst_n        (rst_n),
  .count_up     (count_up),
  .count_down   (count_down),
  .load_n       (load_n),
  .async_clear  (async_clear),
  .load_data    (load_data),
  .count_bit0   (count_bit0),
  .count_bit1   (count_bit1),
  .count_bit2   (count_bit2),
  .count_bit3   (count_bit3),
  .carry_out_n  (carry_out_n),
  .borrow_out_n (borrow_out_n)
);
`default_nettype wire

// [bcd_ctl_model.sv]
// Controller model that pulses one count input
`timescale 1ns/1ps
`default_nettype none
module bcd_ctl_model (
  input  wire logic mclk,
  output var logic  count_up = 1'b1,
  output var logic  count_down = 1'b1
);
  // Each task drives only the chosen input; the other input keeps its level
  task automatic lower(input logic up);
    @(posedge mclk);
    if (up) begin
      count_up <= 1'b0;
    end else begin
      count_down <= 1'b0;
    end
  endtask : lower
  task automatic raise(input logic up);
    @(posedge mclk);
    if (up) begin
      count_up <= 1'b1;
    end else begin
      count_down <= 1'b1;
    end
  endtask : raise
  task automatic pulse(input logic up);
    lower(up);
    raise(up);
    @(posedge mclk) #1;
  endtask : pulse
endmodule : bcd_ctl_model
`default_nettype wire

// [bcd_counter_tb.sv]
// Self-checking testbench for the BCD counter
`timescale 1ns/1ps
`default_nettype none
module bcd_counter_tb;
  logic       mclk;
  logic       rst_n;
  logic       load_n;
  logic       async_clear;
  logic [3:0] load_data;
  wire logic count_up, count_down, count_bit0, count_bit1, count_bit2, count_bit3, carry_out_n, borrow_out_n;
  wire logic [3:0] q = {count_bit3, count_bit2, count_bit1, count_bit0};
  int n_errors = 0, n_tests = 0;
  // Free-running clock, half period of 25 ns
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  bcd_ctl_model i_bcd_ctl_model (
    .mclk       (mclk),
    .count_up   (count_up),
    .count_down (count_down)
  );
  bcd_counter i_bcd_counter (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .count_up     (count_up),
    .count_down   (count_down),
    .load_n       (load_n),
    .async_clear  (async_clear),
    .load_data    (load_data),
    .count_bit0   (count_bit0),
    .count_bit1   (count_bit1),
    .count_bit2   (count_bit2),
    .count_bit3   (count_bit3),
    .carry_out_n  (carry_out_n),
    .borrow_out_n (borrow_out_n)
  );
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Load seven, count up to nine, then wrap with carry
  task automatic t_up;
    @(posedge mclk);
    load_n <= 1'b0;
    load_data <= 4'h7;
    @(posedge mclk);
    load_n <= 1'b1;
    #1 chk(q, 4'h7);
    i_bcd_ctl_model.pulse(1'b1);
    i_bcd_ctl_model.pulse(1'b1);
    chk(q, 4'h9);
    i_bcd_ctl_model.lower(1'b1);
    @(posedge mclk) #1;
    chk({3'h0, carry_out_n}, 4'h0);
    i_bcd_ctl_model.raise(1'b1);
    @(posedge mclk) #1;
    chk(q, 4'h0);
    chk({3'h0, carry_out_n}, 4'h1);
  endtask : t_up
  // Borrow at zero, wrap down to nine, step down to eight, then hold
  task automatic t_down;
    i_bcd_ctl_model.lower(1'b0);
    @(posedge mclk) #1;
    chk({3'h0, borrow_out_n}, 4'h0);
    i_bcd_ctl_model.raise(1'b0);
    @(posedge mclk) #1;
    chk(q, 4'h9);
    chk({3'h0, borrow_out_n}, 4'h1);
    i_bcd_ctl_model.pulse(1'b0);
    chk(q, 4'h8);
    repeat (4) @(posedge mclk);
    #1 chk(q, 4'h8);
  endtask : t_down
  // Up rises while down is low: ignored; down rising afterwards counts
  task automatic t_refuse;
    i_bcd_ctl_model.lower(1'b0);
    i_bcd_ctl_model.pulse(1'b1);
    chk(q, 4'h8);
    i_bcd_ctl_model.raise(1'b0);
    @(posedge mclk) #1;
    chk(q, 4'h7);
  endtask : t_refuse
  // Clear and load together: clear wins
  task automatic t_clear;
    @(posedge mclk);
    async_clear <= 1'b1;
    load_n <= 1'b0;
    @(posedge mclk);
    async_clear <= 1'b0;
    load_n      <= 1'b1;
    #1 chk(q, 4'h0);
  endtask : t_clear
  task automatic conclude;
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  initial begin
    rst_n       <= 1'b0;
    load_n      <= 1'b1;
    async_clear <= 1'b0;
    load_data   <= 4'h0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_up;
    t_down;
    t_refuse;
    t_clear;
    conclude;
  end
endmodule : bcd_counter_tb
`default_nettype wire
